// file: dv/ifs_input_function_selector_props.sv
// Port checks of the input function selector
`timescale 1ns/10ps
`default_nettype none
module ifs_input_function_selector_props
  import ifs_pkg::*;
#(
  parameter int NUM_IN = IFS_NUM_IN
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pins and drive state
  input wire logic [NUM_IN-1:0] digital_input,
  input wire logic safe_hw_enable_input,
  input wire logic power_stage_enable_input,
  input wire logic power_stage_active,
  input wire logic manual_window_active,
  // Outputs
  input wire ifs_func_s func,
  input wire logic hw_enable,
  input wire logic local_override_mode,
  input wire logic fieldbus_override_flag,
  input wire logic control_location_term,
  input wire logic [3:0] active_ref_source,
  input wire logic ref_source_valid,
  input wire logic motor_stop
);
  logic [1:0] warm;
  logic [1:0] next_warm;
  always_comb next_warm = (warm == 2'h3) ? warm : warm + 2'h1;
  always_ff @(posedge ref_clk) warm <= rst ? 2'h0 : next_warm;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_flag; fieldbus_override_flag == local_override_mode; endproperty
  a_flag: assert property (p_flag) else $error("flag differs from mode");
  property p_exit; $fell(local_override_mode) |-> ##[0:1] motor_stop; endproperty
  a_exit: assert property (p_exit) else $error("no stop on exit");
  property p_refuse;
    $rose(local_override_mode) |-> $past(!power_stage_active && !manual_window_active);
  endproperty
  a_refuse: assert property (p_refuse) else $error("entry not refused");
  property p_term; local_override_mode |-> control_location_term; endproperty
  a_term: assert property (p_term) else $error("location not wired");
  property p_valid;
    ref_source_valid == (active_ref_source <= 4'hB && active_ref_source != 4'h4);
  endproperty
  a_valid: assert property (p_valid) else $error("bad source decode");
  property p_hw;
    warm == 2'h3 |-> hw_enable == $past(safe_hw_enable_input && power_stage_enable_input, 3);
  endproperty
  a_hw: assert property (p_hw) else $error("hw enable wrong");
  property p_probe; func.probe_a |-> $past(digital_input[IFS_FAST_A_IDX], 3); endproperty
  a_probe: assert property (p_probe) else $error("probe without pin");
  property p_qstop; func.quick_stop |-> !(&$past(digital_input, 3)); endproperty
  a_qstop: assert property (p_qstop) else $error("stop without low pin");
  property p_neg; func.negate |-> |$past(digital_input, 3); endproperty
  a_neg: assert property (p_neg) else $error("negate without pin");
  property p_wait;
    $rose(local_override_mode) |-> !func.start ##1 !func.start;
  endproperty
  a_wait: assert property (p_wait) else $error("start passed on entry");
endmodule // ifs_input_function_selector_props
bind ifs_input_function_selector ifs_input_function_selector_props #(.NUM_IN(NUM_IN)) u_props (
  .ref_clk, .rst, .digital_input, .safe_hw_enable_input, .power_stage_enable_input,
  .power_stage_active, .manual_window_active, .func, .hw_enable, .local_override_mode,
  .fieldbus_override_flag, .control_location_term, .active_ref_source, .ref_source_valid,
  .motor_stop
);
`default_nettype wire

// file: dv/ifs_input_function_selector_tb_top.sv
// Testbench of the input function selector
`timescale 1ns/10ps
`default_nettype none
module ifs_input_function_selector_tb_top
  import ifs_pkg::*;
;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [6:0] sw_cmd = 0, digital_input, analog_use;
  logic [1:0] en_cmd = 2'h3;
  logic safe_hw_enable_input, power_stage_enable_input, hw_enable, motor_stop;
  logic power_stage_active = 0, manual_window_active = 0, local_override_mode;
  logic fieldbus_override_flag, control_location_term, ref_source_valid;
  logic [3:0] active_ref_source;
  ifs_func_s func;
  localparam logic [55:0] UNDEF = 56'h070D1080F0103F;
  int bad_count = 0, checks = 0, n, k;

  ifs_switch_model u_sw (.ref_clk, .sw_cmd, .en_cmd, .digital_input,
    .safe_hw_enable_input, .power_stage_enable_input);
  ifs_input_function_selector u_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .digital_input, .safe_hw_enable_input,
    .power_stage_enable_input, .power_stage_active, .manual_window_active, .func,
    .hw_enable, .analog_use, .local_override_mode, .fieldbus_override_flag,
    .control_location_term, .active_ref_source, .ref_source_valid, .motor_stop);

  initial forever #2.5 ref_clk = ~ref_clk;

  //==================================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk) penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask
  task automatic pins(input logic [6:0] v);
    sw_cmd <= v;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic sel(input int i, input logic [7:0] c);
    apb(1, IFS_OFF_SEL0 + 8'(4 * i), {24'h0, c});
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    end_of_test;
  end

  //==================================================================
  // Tests
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    apb(0, IFS_OFF_REF_CFG, 0);
    chk(rd, 0);
    for (n = 0; n < 7; n++) begin
      apb(0, IFS_OFF_SEL0 + 8'(4 * n), 0);
      chk(rd, 0);
      sel(n, 8'(n + 1));
      apb(0, IFS_OFF_SEL0 + 8'(4 * n), 0);
      chk(rd, n + 1);
    end
    apb(0, 8'h40, 0);
    chk(err, 1);
    chk(rd, 0);
    apb(1, IFS_OFF_STATUS, 32'hFF);
    chk(err, 1);
    $display("registers done");
    sel(6, IFS_FN_PROBE);
    pins(7'h7F);
    chk(func, 8'hDD);
    pins(0);
    chk(func, 8'h20);
    for (n = 0; n < 7; n++) sel(n, IFS_FN_PROBE);
    pins(7'h7F);
    chk(func, 8'h03);
    for (n = 0; n < 7; n++) sel(n, 8'(IFS_FN_ANA_LOW + n % 5));
    pins(0);
    chk({func, analog_use}, {8'h00, 7'h7F});
    for (n = 0; n < 7; n++) sel(n, UNDEF[8*n+:8]);
    pins(7'h7F);
    chk({func, analog_use}, 0);
    for (n = 0; n < 4; n++) begin
      en_cmd <= 2'(n);
      repeat (6) @(posedge ref_clk);
      chk(hw_enable, n == 3);
    end
    $display("functions done");
    for (n = 2; n < 7; n++) sel(n, IFS_FN_OFF);
    sel(0, IFS_FN_START);
    sel(1, IFS_FN_OVERRIDE);
    pins(0);
    for (n = 0; n < 16; n++) begin
      apb(1, IFS_OFF_REF_CFG, 32'(n) | 32'h30);
      pins(7'h02);
      chk({local_override_mode, fieldbus_override_flag}, 2'h3);
      chk({control_location_term, active_ref_source}, 5'h10 | n);
      chk(ref_source_valid, n < 12 && n != 4);
      sw_cmd <= 0;
      k = 0;
      repeat (8) @(posedge ref_clk) k += motor_stop;
      chk(k, 1);
      chk({local_override_mode, control_location_term, active_ref_source}, 6'h03);
    end
    power_stage_active <= 1;
    pins(7'h02);
    chk(local_override_mode, 0);
    power_stage_active <= 0;
    manual_window_active <= 1;
    repeat (3) @(posedge ref_clk);
    chk(local_override_mode, 0);
    manual_window_active <= 0;
    repeat (3) @(posedge ref_clk);
    chk(local_override_mode, 1);
    pins(0);
    pins(7'h03);
    chk({local_override_mode, func.start}, 2'h2);
    apb(0, IFS_OFF_STATUS, 0);
    chk(rd[IFS_ST_ARMED_BIT], 0);
    pins(7'h02);
    apb(0, IFS_OFF_STATUS, 0);
    chk(rd[IFS_ST_ARMED_BIT], 1);
    pins(7'h03);
    chk(func.start, 1);
    pins(0);
    apb(1, IFS_OFF_REF_CFG, 32'h230);
    pins(7'h02);
    pins(7'h03);
    chk({local_override_mode, func.start}, 2'h2);
    pins(0);
    $display("override done");
    end_of_test;
  end
endmodule // ifs_input_function_selector_tb_top
`default_nettype wire

// file: dv/ifs_switch_model.sv
// Switches and contacts wired to the selector inputs
`timescale 1ns/10ps
`default_nettype none
module ifs_switch_model (
  // Clock
  input wire logic ref_clk,
  // Commanded positions
  input wire logic [6:0] sw_cmd,
  input wire logic [1:0] en_cmd,
  // Contacts at the pins
  output logic [6:0] digital_input,
  output logic safe_hw_enable_input,
  output logic power_stage_enable_input
);
  initial begin
    digital_input = '0;
    {safe_hw_enable_input, power_stage_enable_input} = 2'h0;
  end
  // Contacts settle one cycle after the command
  always @(posedge ref_clk) begin
    digital_input <= sw_cmd;
    {safe_hw_enable_input, power_stage_enable_input} <= en_cmd;
  end
endmodule // ifs_switch_model
`default_nettype wire

// file: logic/ifs_input_function_selector.sv
// Digital input function selector with local override control
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ifs_input_function_selector
  import ifs_pkg::*;
#(
  parameter int NUM_IN = IFS_NUM_IN
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Input pins
  input wire logic [NUM_IN-1:0] digital_input,
  input wire logic safe_hw_enable_input,
  input wire logic power_stage_enable_input,
  // Drive state
  input wire logic power_stage_active,
  input wire logic manual_window_active,
  // Functions to motion control
  output ifs_func_s func,
  output logic hw_enable,
  output logic [NUM_IN-1:0] analog_use,
  // Override and reference selection
  output logic local_override_mode,
  output logic fieldbus_override_flag,
  output logic control_location_term,
  output logic [3:0] active_ref_source,
  output logic ref_source_valid,
  output logic motor_stop
);

  //==================================================================
  // Decode helpers
  typedef enum logic [1:0] {
    IFS_A_SEL = 2'b00,
    IFS_A_CFG = 2'b01,
    IFS_A_STATUS = 2'b11,
    IFS_A_NONE = 2'b10
  } ifs_addr_e;

  function automatic ifs_addr_e addr_kind(input logic [7:0] a);
    if (a[1:0] != 2'b00) begin
      addr_kind = IFS_A_NONE;
    end else if (a >= IFS_OFF_SEL0 && a < IFS_OFF_SEL0 + 8'(NUM_IN * 4)) begin
      addr_kind = IFS_A_SEL;
    end else if (a == IFS_OFF_REF_CFG) begin
      addr_kind = IFS_A_CFG;
    end else if (a == IFS_OFF_STATUS) begin
      addr_kind = IFS_A_STATUS;
    end else begin
      addr_kind = IFS_A_NONE;
    end
  endfunction

  // Effective function of one input, unusable settings become no function
  function automatic logic [7:0] fn_effective(input logic [7:0] sel, input int idx);
    case (sel)
      IFS_FN_START, IFS_FN_NEGATE, IFS_FN_QSTOP, IFS_FN_HALT,
      IFS_FN_LIM_POS, IFS_FN_LIM_NEG, IFS_FN_OVERRIDE: begin
        fn_effective = sel;
      end
      IFS_FN_PROBE: begin
        fn_effective = (idx == IFS_FAST_A_IDX || idx == IFS_FAST_B_IDX) ?
          sel : IFS_FN_OFF;
      end
      default: begin
        fn_effective = IFS_FN_OFF;
      end
    endcase
  endfunction

  function automatic logic ref_valid(input logic [3:0] r);
    ref_valid = (r != IFS_REF_UNDEF) && (r <= IFS_REF_LAST);
  endfunction

  //==================================================================
  // Pin synchronisers
  logic [NUM_IN+1:0] pin_meta;
  logic [NUM_IN+1:0] pin_sync;
  logic [NUM_IN-1:0] in_s;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {power_stage_enable_input, safe_hw_enable_input, digital_input};
      pin_sync <= pin_meta;
    end
  end

  assign in_s = pin_sync[NUM_IN-1:0];

  //==================================================================
  // Register file
  logic [7:0] sel_reg [NUM_IN];
  logic [7:0] next_sel_reg [NUM_IN];
  logic [10:0] ref_cfg;
  logic [10:0] next_ref_cfg;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [31:0] status_word;
  ifs_addr_e akind;
  int sel_idx;

  assign akind = addr_kind(paddr);
  assign sel_idx = int'(paddr[7:2]);
  assign pready = psel & penable;

  always_comb begin
    next_ref_cfg = ref_cfg;
    next_prdata = prdata;
    next_pslverr = pslverr;
    for (int i = 0; i < NUM_IN; i++) begin
      next_sel_reg[i] = sel_reg[i];
    end
    if (psel && !penable) begin
      next_pslverr = (akind == IFS_A_NONE) || (pwrite && akind == IFS_A_STATUS);
      case (akind)
        IFS_A_SEL: next_prdata = {24'h000000, sel_reg[sel_idx]};
        IFS_A_CFG: next_prdata = {21'h000000, ref_cfg};
        IFS_A_STATUS: next_prdata = status_word;
        default: next_prdata = 32'h00000000;
      endcase
    end
    if (psel && penable && pwrite) begin
      case (akind)
        IFS_A_SEL: next_sel_reg[sel_idx] = pwdata[7:0];
        IFS_A_CFG: next_ref_cfg = pwdata[10:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ref_cfg <= IFS_CFG_RESET;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      for (int i = 0; i < NUM_IN; i++) begin
        sel_reg[i] <= IFS_SEL_RESET;
      end
    end else begin
      ref_cfg <= next_ref_cfg;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      for (int i = 0; i < NUM_IN; i++) begin
        sel_reg[i] <= next_sel_reg[i];
      end
    end
  end

  logic [3:0] ovr_ref_src;
  logic [3:0] norm_ref_src;
  logic norm_term;
  logic [1:0] auto_kind;

  assign ovr_ref_src = ref_cfg[IFS_CFG_OVR_REF_LSB +: 4];
  assign norm_ref_src = ref_cfg[IFS_CFG_NORM_REF_LSB +: 4];
  assign norm_term = ref_cfg[IFS_CFG_NORM_TERM_BIT];
  assign auto_kind = ref_cfg[IFS_CFG_AUTO_LSB +: 2];

  //==================================================================
  // Function mapping
  ifs_func_s raw_func;
  logic ovr_req;
  logic [NUM_IN-1:0] ana_flags;
  logic [7:0] code [NUM_IN];

  generate
    for (genvar g = 0; g < NUM_IN; g++) begin : g_in
      assign code[g] = fn_effective(sel_reg[g], g);
      assign ana_flags[g] = $signed(sel_reg[g]) >= $signed(IFS_FN_ANA_LOW) &&
        $signed(sel_reg[g]) < 0;
    end
  endgenerate

  always_comb begin
    raw_func = '0;
    ovr_req = 1'b0;
    raw_func.quick_stop = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      case (code[i])
        IFS_FN_START: raw_func.start |= in_s[i];
        IFS_FN_NEGATE: raw_func.negate |= in_s[i];
        IFS_FN_QSTOP: raw_func.quick_stop |= ~in_s[i];
        IFS_FN_HALT: raw_func.halt |= in_s[i];
        IFS_FN_LIM_POS: raw_func.limit_pos |= in_s[i];
        IFS_FN_LIM_NEG: raw_func.limit_neg |= in_s[i];
        IFS_FN_OVERRIDE: ovr_req |= in_s[i];
        IFS_FN_PROBE: begin
          if (i == IFS_FAST_A_IDX) begin
            raw_func.probe_a = in_s[i];
          end else begin
            raw_func.probe_b = in_s[i];
          end
        end
        default: ;
      endcase
    end
  end

  //==================================================================
  // Override state machine
  ifs_state_e state;
  ifs_state_e next_state;
  ifs_func_s next_func;
  logic next_motor_stop;
  logic next_term;
  logic [3:0] next_ref;
  logic next_hw_enable;
  logic [NUM_IN-1:0] next_analog_use;

  always_comb begin
    next_state = state;
    next_motor_stop = 1'b0;
    case (state)
      IFS_NORMAL: begin
        if (ovr_req && !power_stage_active && !manual_window_active) begin
          next_state = IFS_OVR_WAIT;
        end
      end
      IFS_OVR_WAIT: begin
        if (!ovr_req) begin
          next_state = IFS_NORMAL;
          next_motor_stop = 1'b1;
        end else if (!raw_func.start) begin
          next_state = IFS_OVR_RUN;
        end
      end
      IFS_OVR_RUN: begin
        if (!ovr_req) begin
          next_state = IFS_NORMAL;
          next_motor_stop = 1'b1;
        end
      end
      default: next_state = IFS_NORMAL;
    endcase
    next_func = raw_func;
    // Entry cycle included, so no start leaks out while override begins
    if (state != IFS_NORMAL || next_state != IFS_NORMAL) begin
      // Start from wired input only, armed, and not level triggered
      next_func.start = raw_func.start && state == IFS_OVR_RUN &&
        next_state == IFS_OVR_RUN && auto_kind != IFS_AUTO_LEVEL;
    end
    if (next_state != IFS_NORMAL) begin
      next_term = 1'b1;
      next_ref = ovr_ref_src;
    end else begin
      next_term = norm_term;
      next_ref = norm_ref_src;
    end
    next_hw_enable = pin_sync[NUM_IN] & pin_sync[NUM_IN+1];
    next_analog_use = ana_flags;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= IFS_NORMAL;
      func <= '0;
      motor_stop <= 1'b0;
      control_location_term <= 1'b0;
      active_ref_source <= IFS_REF_NONE;
      hw_enable <= 1'b0;
      analog_use <= '0;
    end else begin
      state <= next_state;
      func <= next_func;
      motor_stop <= next_motor_stop;
      control_location_term <= next_term;
      active_ref_source <= next_ref;
      hw_enable <= next_hw_enable;
      analog_use <= next_analog_use;
    end
  end

  assign local_override_mode = state != IFS_NORMAL;
  assign fieldbus_override_flag = local_override_mode;
  assign ref_source_valid = ref_valid(active_ref_source);

  //==================================================================
  // Status word
  always_comb begin
    status_word = 32'h00000000;
    status_word[IFS_ST_OVR_BIT] = local_override_mode;
    status_word[IFS_ST_TERM_BIT] = control_location_term;
    status_word[IFS_ST_REF_LSB +: 4] = active_ref_source;
    status_word[IFS_ST_VALID_BIT] = ref_source_valid;
    status_word[IFS_ST_ARMED_BIT] = state == IFS_OVR_RUN;
    status_word[IFS_ST_IN_LSB +: NUM_IN] = in_s;
    status_word[IFS_ST_ANA_LSB +: NUM_IN] = analog_use;
  end

endmodule // ifs_input_function_selector
`default_nettype wire

// file: logic/ifs_pkg.sv
// Constants and types of the digital input function selector
//==================================================================
// How it works
// - Every digital input has its own selector register choosing one function.
// - An active override input moves the control location to wired inputs.
// - Entering override also switches the reference source to the override source.
// - Override state is reported on the field bus status flag output.
// - Override is refused while power stage active or manual window active.
// - In override, start is ignored when auto start kind is level (1).
// - Leaving override stops motor control.
// - Override reference source decodes 0 to 11; 4 and above 11 undefined.
// - Safe and power stage enable inputs are fixed, never selectable.
// - Touchprobe works only on the two fast inputs.
// - Selector values -5 to -1 mark the input for analog use.
// - Code 0 no function, 1 start, 2 negate reference.
// - Code 3 quick-stop, input active low.
// - Code 4 halts movement while the input is active.
// - Codes 5 and 6 evaluate positive and negative limit switches.
package ifs_pkg;

  //==================================================================
  // Sizes
  localparam int IFS_NUM_IN = 7;
  localparam int IFS_FAST_A_IDX = 5;
  localparam int IFS_FAST_B_IDX = 6;

  //==================================================================
  // Register offsets
  localparam logic [7:0] IFS_OFF_SEL0 = 8'h00;
  localparam logic [7:0] IFS_OFF_REF_CFG = 8'h20;
  localparam logic [7:0] IFS_OFF_STATUS = 8'h24;

  //==================================================================
  // Reference configuration fields
  localparam int IFS_CFG_OVR_REF_LSB = 0;
  localparam int IFS_CFG_NORM_REF_LSB = 4;
  localparam int IFS_CFG_NORM_TERM_BIT = 8;
  localparam int IFS_CFG_AUTO_LSB = 9;
  localparam logic [10:0] IFS_CFG_RESET = 11'h000;
  localparam logic [7:0] IFS_SEL_RESET = 8'h00;

  //==================================================================
  // Status fields
  localparam int IFS_ST_OVR_BIT = 0;
  localparam int IFS_ST_TERM_BIT = 1;
  localparam int IFS_ST_REF_LSB = 2;
  localparam int IFS_ST_VALID_BIT = 6;
  localparam int IFS_ST_ARMED_BIT = 7;
  localparam int IFS_ST_IN_LSB = 8;
  localparam int IFS_ST_ANA_LSB = 16;

  //==================================================================
  // Function codes
  localparam logic [7:0] IFS_FN_OFF = 8'h00;
  localparam logic [7:0] IFS_FN_START = 8'h01;
  localparam logic [7:0] IFS_FN_NEGATE = 8'h02;
  localparam logic [7:0] IFS_FN_QSTOP = 8'h03;
  localparam logic [7:0] IFS_FN_HALT = 8'h04;
  localparam logic [7:0] IFS_FN_LIM_POS = 8'h05;
  localparam logic [7:0] IFS_FN_LIM_NEG = 8'h06;
  localparam logic [7:0] IFS_FN_OVERRIDE = 8'h0E;
  localparam logic [7:0] IFS_FN_PROBE = 8'h0F;
  localparam logic [7:0] IFS_FN_ANA_LOW = 8'hFB;

  //==================================================================
  // Reference sources and start trigger kinds
  localparam logic [3:0] IFS_REF_NONE = 4'h0;
  localparam logic [3:0] IFS_REF_UNDEF = 4'h4;
  localparam logic [3:0] IFS_REF_LAST = 4'hB;
  localparam logic [1:0] IFS_AUTO_LEVEL = 2'h1;

  //==================================================================
  // Types
  typedef enum logic [1:0] {
    IFS_NORMAL = 2'b00,
    IFS_OVR_WAIT = 2'b01,
    IFS_OVR_RUN = 2'b11
  } ifs_state_e;

  typedef struct packed {
    logic start;
    logic negate;
    logic quick_stop;
    logic halt;
    logic limit_pos;
    logic limit_neg;
    logic probe_a;
    logic probe_b;
  } ifs_func_s;

endpackage
